//--- hw/dmaph_ctrl.sv
// controller end: serves peripheral requests, bus request and terminal count
`include "dmaph_map.svh"
module dmaph_ctrl #(
   parameter int CW = `DMAPH_CNT_W
) (
   input wire logic clk_i,
   input wire logic srst_i,
   dmaph_if.ctrl pif,
   input wire logic enable_i,
   input wire dmaph_pkg::dmaph_flow_t flow_i,
   input wire logic [CW-1:0] packet_len_i,
   input wire logic [CW-1:0] burst_size_i,
   input wire logic tc_irq_en_i,
   input wire logic port_sel_i,
   input wire logic bus_grant_port1_i,
   input wire logic bus_grant_port2_i,
   input wire logic bus_ready_i,
   output logic bus_request_port1_o,
   output logic bus_request_port2_o,
   output logic word_strobe_o,
   output logic tc_irq_o,
   output logic next_item_o,
   output logic busy_o
);
   import dmaph_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bus wanted only in the move state, also while waiting for grant
   function automatic logic wants_bus(input dmaph_state_t cur);
      return cur == DMAPH_MOVE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   dmaph_state_t state;
   logic [CW-1:0] remaining;
   logic [CW-1:0] beats;
   logic last_req;
   logic owner;
   logic grant_sel;
   logic want_burst;
   logic want_single;
   logic want_lburst;
   logic want_lsingle;
   logic any_req;
   logic [CW-1:0] next_beats;
   logic take_req;
   logic word_go;
   logic pkt_end;

   ////////////////////////////////////////////////////////////////////////////
   // request decode
   always_comb begin
      want_burst = pif.burst_request_line;
      want_single = pif.single_request_line;
      want_lburst = pif.last_burst_request_line;
      want_lsingle = pif.last_single_request_line;
      next_beats = '0;
      any_req = 1'b0;
      if (flow_i == DMAPH_FLOW_CTRL) begin
         if (remaining > burst_size_i) begin
            any_req = want_burst;
            next_beats = burst_size_i;
         end else if (remaining != '0) begin
            any_req = want_single | want_burst;
            next_beats = want_single ? CW'(1) : remaining;
         end
      end else begin
         any_req = want_burst | want_single | want_lburst | want_lsingle;
         next_beats = (want_burst | want_lburst) ? burst_size_i : CW'(1);
      end
   end

   assign grant_sel = port_sel_i ? bus_grant_port2_i : bus_grant_port1_i;

   ////////////////////////////////////////////////////////////////////////////
   // request take, word step and packet end
   always_comb begin
      take_req = (state == DMAPH_IDLE) && enable_i && any_req;
      word_go = wants_bus(state) && owner && (beats != '0);
      pkt_end = 1'b0;
      if (flow_i == DMAPH_FLOW_CTRL) begin
         pkt_end = (remaining == '0);
      end else begin
         pkt_end = last_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus ownership
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         owner <= 1'b0;
      end else if (!wants_bus(state)) begin
         owner <= 1'b0;
      end else if (grant_sel && bus_ready_i) begin
         owner <= 1'b1;
      end
   end
   always_comb begin
      bus_request_port1_o = wants_bus(state) && !port_sel_i;
      bus_request_port2_o = wants_bus(state) && port_sel_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= DMAPH_IDLE;
      end else begin
         unique case (state)
            DMAPH_IDLE: begin
               if (take_req) begin
                  state <= DMAPH_BUSREQ;
               end
            end
            DMAPH_BUSREQ: begin
               state <= DMAPH_MOVE;
            end
            DMAPH_MOVE: begin
               if (owner && beats <= CW'(1)) begin
                  state <= DMAPH_CLEAR;
               end
            end
            DMAPH_CLEAR: begin
               if (pkt_end) begin
                  state <= DMAPH_TC;
               end else begin
                  state <= DMAPH_IDLE;
               end
            end
            DMAPH_TC: begin
               state <= DMAPH_IRQ;
            end
            DMAPH_IRQ: begin
               state <= DMAPH_NEXT;
            end
            DMAPH_NEXT: begin
               state <= DMAPH_IDLE;
            end
            default: begin
               state <= DMAPH_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // words left in the current request
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         beats <= '0;
      end else if (take_req) begin
         beats <= next_beats;
      end else if (word_go) begin
         beats <= beats - CW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // kind of the request being served
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         last_req <= 1'b0;
      end else if (take_req) begin
         last_req <= want_lburst | want_lsingle;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // remaining packet count
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         remaining <= `DMAPH_LEN_RST;
      end else if (state == DMAPH_NEXT || (state == DMAPH_IDLE && !enable_i)) begin
         remaining <= packet_len_i;
      end else if (word_go && remaining != '0) begin
         remaining <= remaining - CW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         word_strobe_o <= 1'b0;
      end else begin
         word_strobe_o <= word_go;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt the cycle after terminal count
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tc_irq_o <= 1'b0;
      end else begin
         tc_irq_o <= (state == DMAPH_TC) && tc_irq_en_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // handshake pulses and status
   always_comb begin
      pif.request_clear_ack = (state == DMAPH_CLEAR);
      pif.terminal_count_line = (state == DMAPH_TC);
      next_item_o = (state == DMAPH_NEXT);
      busy_o = (state != DMAPH_IDLE);
   end
endmodule

//--- include/dmaph_map.svh
// constants for the dma peripheral handshake
`ifndef DMAPH_MAP_SVH
`define DMAPH_MAP_SVH
`define DMAPH_CNT_W 12
`define DMAPH_BURST_RST 12'h004
`define DMAPH_LEN_RST 12'h000
`define DMAPH_WORD_CYCLES 1
`endif

//--- include/dmaph_pkg.sv
// types for the dma peripheral handshake
package dmaph_pkg;
   typedef enum logic [2:0] {
      DMAPH_IDLE = 3'h0,
      DMAPH_BUSREQ = 3'h1,
      DMAPH_MOVE = 3'h3,
      DMAPH_CLEAR = 3'h2,
      DMAPH_TC = 3'h6,
      DMAPH_IRQ = 3'h7,
      DMAPH_NEXT = 3'h5
   } dmaph_state_t;
   typedef enum logic [1:0] {
      DMAPH_FLOW_CTRL = 2'h0,
      DMAPH_FLOW_PERIPH = 2'h1
   } dmaph_flow_t;
endpackage

//--- include/dmaph_if.sv
// request and response wires between peripheral and controller
interface dmaph_if;
   logic burst_request_line;
   logic single_request_line;
   logic last_burst_request_line;
   logic last_single_request_line;
   logic request_clear_ack;
   logic terminal_count_line;
   modport ctrl (
      input burst_request_line,
      input single_request_line,
      input last_burst_request_line,
      input last_single_request_line,
      output request_clear_ack,
      output terminal_count_line
   );
   modport periph (
      output burst_request_line,
      output single_request_line,
      output last_burst_request_line,
      output last_single_request_line,
      input request_clear_ack,
      input terminal_count_line
   );
endinterface

//--- hw/dmaph_periph.sv
// peripheral end: raises burst, single and last requests and waits for clear
`include "dmaph_map.svh"
module dmaph_periph (
   input wire logic clk_i,
   input wire logic srst_i,
   dmaph_if.periph pif,
   input wire logic req_valid_i,
   input wire logic req_burst_i,
   input wire logic req_last_i,
   output logic req_ready_o,
   output logic done_o,
   output logic packet_end_o
);
   import dmaph_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   logic pending;
   logic burst_q;
   logic last_q;
   ////////////////////////////////////////////////////////////////////////////
   // request hold until clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pending <= 1'b0;
         burst_q <= 1'b0;
         last_q <= 1'b0;
      end else if (pending) begin
         if (pif.request_clear_ack) begin
            pending <= 1'b0;
         end
      end else if (req_valid_i && !pif.request_clear_ack) begin
         pending <= 1'b1;
         burst_q <= req_burst_i;
         last_q <= req_last_i;
      end
   end
   always_comb begin
      req_ready_o = !pending && !pif.request_clear_ack;
      pif.burst_request_line = pending && burst_q && !last_q;
      pif.single_request_line = pending && !burst_q && !last_q;
      pif.last_burst_request_line = pending && burst_q && last_q;
      pif.last_single_request_line = pending && !burst_q && last_q;
   end
   ////////////////////////////////////////////////////////////////////////////
   // response flags
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         done_o <= 1'b0;
         packet_end_o <= 1'b0;
      end else begin
         done_o <= pending && pif.request_clear_ack;
         packet_end_o <= pif.terminal_count_line;
      end
   end
endmodule

//--- tb/dmaph_chk.sv
// assertions on the peripheral handshake wires
module dmaph_chk (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic burst_request_line,
   input wire logic single_request_line,
   input wire logic last_burst_request_line,
   input wire logic last_single_request_line,
   input wire logic request_clear_ack,
   input wire logic terminal_count_line
);
   timeunit 1ns;
   timeprecision 1ps;
   wire b = burst_request_line;
   wire s = single_request_line;
   wire lb = last_burst_request_line;
   wire ls = last_single_request_line;
   wire clr = request_clear_ack;
   wire tc = terminal_count_line;
   wire any_req = b | s | lb | ls;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_release;
      ##1 !any_req;
   endsequence
   chk_clear_pulse: assert property (clr |=> !clr)
      else $error("clear wider than one cycle");
   chk_clear_on_req: assert property (clr |-> any_req)
      else $error("clear without request");
   chk_tc_after_clear: assert property (tc |-> $past(clr))
      else $error("terminal count not after clear");
   chk_tc_pulse: assert property (tc |=> !tc)
      else $error("terminal count wider than one cycle");
   chk_req_drop: assert property (clr |-> s_release)
      else $error("request kept after clear");
   chk_req_hold: assert property (any_req && !clr |=> any_req)
      else $error("request dropped before clear");
   chk_burst_excl: assert property (!(b && lb))
      else $error("burst and last burst together");
   chk_single_excl: assert property (!(s && ls))
      else $error("single and last single together");
   chk_one_kind: assert property ($onehot0({b, s, lb, ls}))
      else $error("several request lines high");
endmodule

//--- tb/tb_top.sv
// testbench joining controller and peripheral ends
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dmaph_pkg::*;
   logic clk_i = 0, srst_i = 1, en = 0, ie = 0, sel = 0, g1 = 1, g2 = 1, rdy = 1;
   logic rv = 0, rb = 0, rl = 0;
   dmaph_flow_t flow = DMAPH_FLOW_CTRL;
   logic [11:0] len = 12'h000;
   logic rr, dn, wst, irq, nxt, bq1, bq2, pe, bsy;
   int cyc, words, tcs, irqs, tc_at, irq_at, nxt_at, pends, miscompares, checks_done;
   dmaph_if dif();
   dmaph_ctrl u_dmaph_ctrl (.clk_i(clk_i), .srst_i(srst_i), .pif(dif.ctrl), .enable_i(en),
      .flow_i(flow), .packet_len_i(len), .burst_size_i(12'h004), .tc_irq_en_i(ie),
      .port_sel_i(sel), .bus_grant_port1_i(g1), .bus_grant_port2_i(g2), .bus_ready_i(rdy),
      .bus_request_port1_o(bq1), .bus_request_port2_o(bq2), .word_strobe_o(wst),
      .tc_irq_o(irq), .next_item_o(nxt), .busy_o(bsy));
   dmaph_periph u_dmaph_periph (.clk_i(clk_i), .srst_i(srst_i), .pif(dif.periph),
      .req_valid_i(rv), .req_burst_i(rb), .req_last_i(rl), .req_ready_o(rr), .done_o(dn),
      .packet_end_o(pe));
   dmaph_chk u_dmaph_chk (.clk_i(clk_i), .srst_i(srst_i),
      .burst_request_line(dif.burst_request_line),
      .single_request_line(dif.single_request_line),
      .last_burst_request_line(dif.last_burst_request_line),
      .last_single_request_line(dif.last_single_request_line),
      .request_clear_ack(dif.request_clear_ack),
      .terminal_count_line(dif.terminal_count_line));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks_done++;
      if (got !== ex) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
      end
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (wst === 1'b1) words <= words + 1;
      if (dif.terminal_count_line === 1'b1) tc_at <= cyc;
      if (dif.terminal_count_line === 1'b1) tcs <= tcs + 1;
      if (irq === 1'b1) irq_at <= cyc;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (nxt === 1'b1) nxt_at <= cyc;
      if (pe === 1'b1) pends <= pends + 1;
      if (cyc == 2000) begin
         miscompares++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cfg(input dmaph_flow_t f, input logic [11:0] l, input logic i, input logic s);
      @(posedge clk_i);
      en <= 1'b0;
      flow <= f;
      len <= l;
      ie <= i;
      sel <= s;
      repeat (2) @(posedge clk_i);
      en <= 1'b1;
   endtask
   task automatic xfer(input logic b, l, input int dly, input logic [31:0] ew, et, ei);
      int w0, t0, i0, p0, n;
      w0 = words;
      p0 = pends;
      t0 = tcs;
      i0 = irqs;
      n = 0;
      @(posedge clk_i);
      rv <= 1'b1;
      rb <= b;
      rl <= l;
      g1 <= (dly == 0) || sel;
      g2 <= (dly == 0) || !sel;
      @(negedge clk_i);
      while (rr !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      chk("request ready", 32'h1, {31'h0, rr});
      @(posedge clk_i);
      rv <= 1'b0;
      repeat (dly) @(negedge clk_i);
      if (dly > 0) begin
         chk("port2 request", {31'h0, sel}, {31'h0, bq2});
         chk("port1 request", {31'h0, ~sel}, {31'h0, bq1});
         chk("words before grant", 32'h0, words - w0);
      end
      @(posedge clk_i);
      g1 <= 1'b1;
      g2 <= 1'b1;
      rdy <= (dly == 0);
      if (dly > 0) begin
         repeat (dly) @(negedge clk_i);
         chk("words before ready", 32'h0, words - w0);
         @(posedge clk_i);
         rdy <= 1'b1;
      end
      n = 0;
      while (dn !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      chk("clear seen", 32'h1, {31'h0, dn});
      repeat (4) @(negedge clk_i);
      chk("packet end", et, pends - p0);
      chk("busy after transfer", 32'h0, {31'h0, bsy});
      chk("words", ew, words - w0);
      chk("terminal count", et, tcs - t0);
      chk("interrupt", ei, irqs - i0);
      if (ei) chk("interrupt after tc", 32'h1, irq_at - tc_at);
      if (et) chk("next item after tc", 32'h2, nxt_at - tc_at);
   endtask
   task automatic t_ctrl_flow();
      cfg(DMAPH_FLOW_CTRL, 12'h006, 1'b1, 1'b0);
      xfer(1'b1, 1'b0, 0, 32'h4, 32'h0, 32'h0);
      xfer(1'b0, 1'b0, 0, 32'h1, 32'h0, 32'h0);
      xfer(1'b1, 1'b0, 0, 32'h1, 32'h1, 32'h1);
      $display("test ctrl flow done");
   endtask
   task automatic t_periph_flow();
      cfg(DMAPH_FLOW_PERIPH, 12'h000, 1'b0, 1'b1);
      xfer(1'b0, 1'b0, 6, 32'h1, 32'h0, 32'h0);
      xfer(1'b1, 1'b1, 0, 32'h4, 32'h1, 32'h0);
      $display("test periph flow done");
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      srst_i <= 1'b0;
      t_ctrl_flow();
      t_periph_flow();
      give_verdict();
   end
endmodule
